/* File: inc/readback_pkg.sv */
// readback_pkg: command codes, byte counts, reset values and the status carriers
// for the host read-back responder.
// assumes an 8-bit parallel command/parameter bus with active-low strobes.
package readback_pkg;

  // command codes written with the select line low
  localparam logic [7:0] CMD_SOFT_RESET        = 8'h01;
  localparam logic [7:0] CMD_READ_IDENTIFY     = 8'h04;
  localparam logic [7:0] CMD_READ_STATUS_WORD  = 8'h09;
  localparam logic [7:0] CMD_READ_POWER_STATE  = 8'h0a;

  // parameter bytes returned after each read command, dummy byte included
  localparam logic [2:0] IDENTIFY_BYTES        = 3'h4;
  localparam logic [2:0] STATUS_WORD_BYTES     = 3'h5;
  localparam logic [2:0] POWER_STATE_BYTES     = 3'h2;

  // reset values of the host-facing state
  localparam logic [7:0] DATA_OUT_RESET        = 8'h00;
  localparam logic [7:0] DUMMY_BYTE            = 8'h00;
  localparam logic [2:0] STROBE_PIPE_RESET     = 3'h7;
  localparam logic [2:0] SELECT_PIPE_RESET     = 3'h0;

  // interface pixel format codes
  localparam logic [2:0] PIXEL_FORMAT_16BPP    = 3'h5;
  localparam logic [2:0] PIXEL_FORMAT_18BPP    = 3'h6;

  // live state of the display, supplied by the blocks that own it
  typedef struct packed {
    logic       booster_ok;
    logic [5:0] memory_access_control_setting;  // setting bits 7..2
    logic [2:0] pixel_format;
    logic       idle_on;
    logic       partial_on;
    logic       sleep_out;
    logic       normal_on;
    logic       display_on;
    logic       tearing_line_on;
    logic [2:0] gamma_curve;
    logic       tearing_mode;
  } display_state_t;

  // 32-bit status word, most significant field first
  typedef struct packed {
    logic       booster_ok;           // 31
    logic [5:0] access_order;         // 30..25
    logic [1:0] unused_24_23;
    logic [2:0] pixel_format;         // 22..20
    logic       idle_on;              // 19
    logic       partial_on;           // 18
    logic       sleep_out;            // 17
    logic       normal_on;            // 16
    logic [4:0] unused_15_11;
    logic       display_on;           // 10
    logic       tearing_line_on;      // 9
    logic [2:0] gamma_curve;          // 8..6
    logic       tearing_mode;         // 5
    logic [4:0] unused_4_0;
  } status_word_t;

  typedef enum logic [3:0] {
    MODE_NONE     = 4'b0001,
    MODE_IDENTIFY = 4'b0010,
    MODE_STATUS   = 4'b0100,
    MODE_POWER    = 4'b1000
  } read_mode_t;

endpackage : readback_pkg

/* File: design/display_status_readback.sv */
// display_status_readback: answers the identification, status word and power
// state read commands over the parallel host bus.
// assumes the host pins are asynchronous to core_clk_in and that every strobe
// phase lasts well over three clock periods; state inputs are on core_clk_in.
//
// How it works
// - identify command returns 24 identity bits over the following parameter reads.
// - first parameter read after any read command is a dummy byte to discard.
// - identity bytes follow in order maker, version, driver.
// - status word command returns dummy then four bytes, most significant first.
// - status bit 31 is one while the booster is on and healthy.
// - status bits 30..25 mirror memory access control setting bits 7..2.
// - status bits 22..20 carry the pixel format, 101 or 110.
// - bits 19..16 show idle on, partial on, sleep exited, normal on.
// - status bit 9 is one while the tearing line output is enabled.
// - status bit 5 shows tearing mode, vertical only or both blankings.
// - power state command returns dummy then one status byte.
// - power byte bits 7..2: booster, idle, partial, sleep out, normal, display.
// - all three read commands are honoured in every operating state.
// - returned bytes reflect the live state inputs with no frame delay.
`timescale 1ns/1ps
module display_status_readback
  import readback_pkg::*;
#(
  parameter logic [7:0] MAKER_IDENTITY_BYTE   = 8'h5a,  // arbitrary value
  parameter logic [7:0] VERSION_IDENTITY_BYTE = 8'h01,  // arbitrary value
  parameter logic [7:0] DRIVER_IDENTITY_BYTE  = 8'h3c   // arbitrary value
) (
  // clock and reset
  input  wire logic           core_clk_in,
  input  wire logic           resetn_in,
  // host bus pins
  input  wire logic           data_command_select_in,
  input  wire logic           read_strobe_n_in,
  input  wire logic           write_strobe_n_in,
  input  wire logic [7:0]     host_data_in,
  output logic      [7:0]     host_data_out,
  output logic                host_data_oe_out,
  // live display state
  input  wire display_state_t state_in
);

  // three-stage pipes on every pin; only stage 1 reads stage 0
  logic [2:0] rd_pipe_q, rd_pipe_d;
  logic [2:0] wr_pipe_q, wr_pipe_d;
  logic [2:0] sel_pipe_q, sel_pipe_d;
  logic [7:0] dat_pipe0_q, dat_pipe1_q, dat_pipe2_q;
  logic       rd_level_q, rd_level_d;
  logic       wr_level_q, wr_level_d;
  logic       sel_level_q, sel_level_d;

  always_comb begin
    rd_pipe_d  = {rd_pipe_q[1:0], read_strobe_n_in};
    wr_pipe_d  = {wr_pipe_q[1:0], write_strobe_n_in};
    sel_pipe_d = {sel_pipe_q[1:0], data_command_select_in};
    // a change is taken only once stages 1 and 2 agree
    rd_level_d  = (rd_pipe_q[1] == rd_pipe_q[2]) ? rd_pipe_q[2] : rd_level_q;
    wr_level_d  = (wr_pipe_q[1] == wr_pipe_q[2]) ? wr_pipe_q[2] : wr_level_q;
    sel_level_d = (sel_pipe_q[1] == sel_pipe_q[2]) ? sel_pipe_q[2] : sel_level_q;
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      // idle strobe levels, so leaving reset shows no false edge
      rd_pipe_q   <= STROBE_PIPE_RESET;
      wr_pipe_q   <= STROBE_PIPE_RESET;
      sel_pipe_q  <= SELECT_PIPE_RESET;
      dat_pipe0_q <= DATA_OUT_RESET;
      dat_pipe1_q <= DATA_OUT_RESET;
      dat_pipe2_q <= DATA_OUT_RESET;
      rd_level_q  <= 1'b1;
      wr_level_q  <= 1'b1;
      sel_level_q <= 1'b0;
    end else begin
      rd_pipe_q   <= rd_pipe_d;
      wr_pipe_q   <= wr_pipe_d;
      sel_pipe_q  <= sel_pipe_d;
      // no vote on data: it is read only at a filtered write edge, long after settling
      dat_pipe0_q <= host_data_in;
      dat_pipe1_q <= dat_pipe0_q;
      dat_pipe2_q <= dat_pipe1_q;
      rd_level_q  <= rd_level_d;
      wr_level_q  <= wr_level_d;
      sel_level_q <= sel_level_d;
    end
  end

  // strobe edges seen on the filtered levels
  logic write_rise;
  logic read_fall;
  logic read_rise;

  // edges compare the held level with the next one, so each lasts one cycle
  always_comb begin
    write_rise = !wr_level_q && wr_level_d;
    read_fall  = rd_level_q && !rd_level_d;
    read_rise  = !rd_level_q && rd_level_d;
  end

  // status word assembled from the live inputs, so a new setting shows at once
  status_word_t status_word;
  logic [7:0]   power_byte;

  always_comb begin
    status_word                 = '0;
    status_word.booster_ok      = state_in.booster_ok;
    status_word.access_order    = state_in.memory_access_control_setting;
    status_word.pixel_format    = state_in.pixel_format;
    status_word.idle_on         = state_in.idle_on;
    status_word.partial_on      = state_in.partial_on;
    status_word.sleep_out       = state_in.sleep_out;
    status_word.normal_on       = state_in.normal_on;
    status_word.display_on      = state_in.display_on;
    status_word.tearing_line_on = state_in.tearing_line_on;
    status_word.gamma_curve     = state_in.gamma_curve;
    status_word.tearing_mode    = state_in.tearing_mode;
    // power byte bits 1..0 are not defined and stay zero
    power_byte = {state_in.booster_ok, state_in.idle_on, state_in.partial_on,
                  state_in.sleep_out, state_in.normal_on, state_in.display_on,
                  2'b00};
  end

  // command decode and byte sequencing
  read_mode_t mode_q, mode_d;
  logic [2:0] index_q, index_d;
  logic [7:0] data_q, data_d;
  logic       oe_q, oe_d;
  logic [7:0] next_byte;
  logic [2:0] byte_count;

  always_comb begin
    next_byte  = DUMMY_BYTE;
    byte_count = 3'h0;
    // slot 0 is the dummy for every command; later slots pick identity parameters or live status bytes
    case (mode_q)
      MODE_IDENTIFY: begin
        byte_count = IDENTIFY_BYTES;
        case (index_q)
          3'h1:    next_byte = MAKER_IDENTITY_BYTE;
          3'h2:    next_byte = VERSION_IDENTITY_BYTE;
          3'h3:    next_byte = DRIVER_IDENTITY_BYTE;
          default: next_byte = DUMMY_BYTE;
        endcase
      end
      MODE_STATUS: begin
        byte_count = STATUS_WORD_BYTES;
        case (index_q)
          3'h1:    next_byte = status_word[31:24];
          3'h2:    next_byte = status_word[23:16];
          3'h3:    next_byte = status_word[15:8];
          3'h4:    next_byte = status_word[7:0];
          default: next_byte = DUMMY_BYTE;
        endcase
      end
      MODE_POWER: begin
        byte_count = POWER_STATE_BYTES;
        next_byte  = (index_q == 3'h1) ? power_byte : DUMMY_BYTE;
      end
      MODE_NONE: begin
        byte_count = 3'h0;
        next_byte  = DUMMY_BYTE;
      end
      default: begin
        byte_count = 3'h0;
        next_byte  = DUMMY_BYTE;
      end
    endcase
  end

  // limitation: a strobe phase shorter than two clocks may be missed
  always_comb begin
    mode_d  = mode_q;
    index_d = index_q;
    data_d  = data_q;
    oe_d    = oe_q;
    // a command write ends any read sequence; no mode gating on purpose
    if (write_rise && !sel_level_q) begin
      index_d = 3'h0;
      oe_d    = 1'b0;
      case (dat_pipe2_q)
        CMD_READ_IDENTIFY:    mode_d = MODE_IDENTIFY;
        CMD_READ_STATUS_WORD: mode_d = MODE_STATUS;
        CMD_READ_POWER_STATE: mode_d = MODE_POWER;
        CMD_SOFT_RESET:       mode_d = MODE_NONE;
        default:              mode_d = MODE_NONE;
      endcase
    end else if (read_fall && sel_level_q) begin
      // bus is driven for every parameter read (select high), with zero once the sequence is spent
      oe_d   = 1'b1;
      data_d = (index_q < byte_count) ? next_byte : DUMMY_BYTE;
    end else if (read_rise) begin
      oe_d = 1'b0;
      // index stops at the byte count, so further reads return zero
      if (oe_q && index_q < byte_count) begin
        index_d = index_q + 3'h1;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      mode_q  <= MODE_NONE;
      index_q <= 3'h0;
      data_q  <= DATA_OUT_RESET;
      oe_q    <= 1'b0;
    end else begin
      mode_q  <= mode_d;
      index_q <= index_d;
      data_q  <= data_d;
      oe_q    <= oe_d;
    end
  end

  // outputs come straight from flops, nothing between them and the pins
  always_comb begin
    host_data_out    = data_q;
    host_data_oe_out = oe_q;
  end

endmodule : display_status_readback

/* File: verif/display_status_readback_props.sv */
// checker: byte order and strobe timing of the read-back responder
// assumes every host strobe phase lasts at least four clocks
`timescale 1ns/1ps
module display_status_readback_props
  import readback_pkg::*;
#(
  // arbitrary identity values
  parameter logic [7:0] MAKER_IDENTITY_BYTE   = 8'h5a,
  parameter logic [7:0] VERSION_IDENTITY_BYTE = 8'h01,
  parameter logic [7:0] DRIVER_IDENTITY_BYTE  = 8'h3c
) (
  // watched pins and state
  input wire logic           core_clk_in,
  input wire logic           resetn_in,
  input wire logic           data_command_select_in,
  input wire logic           read_strobe_n_in,
  input wire logic           write_strobe_n_in,
  input wire logic [7:0]     host_data_in,
  input wire logic [7:0]     host_data_out,
  input wire logic           host_data_oe_out,
  input wire display_state_t state_in
);
  logic [7:0]     cmd_q, cmd_d, id_b, pw_b, wd_b;
  logic [2:0]     idx_q, idx_d;
  logic           wr_n_q, oe_q, up, tail;
  logic [31:0]    word;
  display_state_t s_q;
  always_comb begin
    cmd_d = cmd_q;
    idx_d = idx_q;
    if (write_strobe_n_in && !wr_n_q && !data_command_select_in) begin
      cmd_d = host_data_in;
      idx_d = 3'h0;
    end else if (oe_q && !host_data_oe_out && idx_q != 3'h7) begin
      idx_d = idx_q + 3'h1;
    end
    word = {s_q.booster_ok, s_q.memory_access_control_setting, 2'h0, s_q.pixel_format,
            s_q.idle_on, s_q.partial_on, s_q.sleep_out, s_q.normal_on, 5'h00,
            s_q.display_on, s_q.tearing_line_on, s_q.gamma_curve, s_q.tearing_mode, 5'h00};
    wd_b = 8'(word >> (6'd32 - {idx_q, 3'h0}));
    id_b = (idx_q == 3'h1) ? MAKER_IDENTITY_BYTE :
           (idx_q == 3'h2) ? VERSION_IDENTITY_BYTE : DRIVER_IDENTITY_BYTE;
    pw_b = {s_q.booster_ok, s_q.idle_on, s_q.partial_on, s_q.sleep_out, s_q.normal_on,
            s_q.display_on, 2'h0};
    up = host_data_oe_out && !oe_q;
    tail = !((cmd_q == CMD_READ_IDENTIFY && idx_q < IDENTIFY_BYTES) ||
             (cmd_q == CMD_READ_STATUS_WORD && idx_q < STATUS_WORD_BYTES) ||
             (cmd_q == CMD_READ_POWER_STATE && idx_q < POWER_STATE_BYTES));
  end
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      cmd_q  <= 8'h00;
      idx_q  <= 3'h0;
      wr_n_q <= 1'b1;
      oe_q   <= 1'b0;
    end else begin
      cmd_q  <= cmd_d;
      idx_q  <= idx_d;
      wr_n_q <= write_strobe_n_in;
      oe_q   <= host_data_oe_out;
    end
    s_q <= state_in;
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  // a read release must end the drive within the sync latency
  sequence s_release;
    $rose(read_strobe_n_in);
  endsequence
  a_dummy_first: assert property (up && idx_q == 3'h0 |-> host_data_out == DUMMY_BYTE)
    else $error("first byte after a read command is not the dummy");
  a_ident_order: assert property (up && cmd_q == CMD_READ_IDENTIFY && idx_q != 3'h0 && !tail
    |-> host_data_out == id_b) else $error("identity byte out of order");
  a_status_bytes: assert property (up && cmd_q == CMD_READ_STATUS_WORD && idx_q != 3'h0 && !tail
    |-> host_data_out == wd_b) else $error("status word byte wrong");
  a_power_byte: assert property (up && cmd_q == CMD_READ_POWER_STATE && idx_q == 3'h1
    |-> host_data_out == pw_b) else $error("power state byte wrong");
  a_tail_zero: assert property (up && tail |-> host_data_out == 8'h00)
    else $error("byte past the sequence is not zero");
  a_read_cause: assert property (up |-> !$past(read_strobe_n_in) && !$past(read_strobe_n_in, 3)
    && $past(data_command_select_in, 3)) else $error("drive without a parameter read");
  a_drive_release: assert property (s_release |-> ##[1:7] !host_data_oe_out)
    else $error("bus still driven after read release");
  a_data_stands: assert property (host_data_oe_out && oe_q |-> $stable(host_data_out))
    else $error("driven byte changed mid read");
endmodule : display_status_readback_props
bind display_status_readback display_status_readback_props #(
  .MAKER_IDENTITY_BYTE(MAKER_IDENTITY_BYTE), .VERSION_IDENTITY_BYTE(VERSION_IDENTITY_BYTE),
  .DRIVER_IDENTITY_BYTE(DRIVER_IDENTITY_BYTE)
) u_props (.core_clk_in, .resetn_in, .data_command_select_in, .read_strobe_n_in,
  .write_strobe_n_in, .host_data_in, .host_data_out, .host_data_oe_out, .state_in);

/* File: verif/host_bus_model.sv */
// host model: writes command bytes and strobes parameter reads
// assumes calls start on a falling clock edge
`timescale 1ns/1ps
module host_bus_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] dev_data_in,
  input  wire logic       dev_oe_in,
  output logic            sel_out,
  output logic            rd_n_out,
  output logic            wr_n_out,
  output logic [7:0]      data_out
);
  initial begin
    sel_out = 1'b1;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    data_out = 8'h00;
  end
  task automatic cmd(input logic [7:0] code);
    sel_out = 1'b0;
    data_out = code;
    wr_n_out = 1'b0;
    repeat (8) @(negedge clk_in);
    wr_n_out = 1'b1;
    repeat (8) @(negedge clk_in);
  endtask : cmd
  task automatic rd(input logic sel, output logic [8:0] b);
    sel_out = sel;
    data_out = ~data_out;  // released lines never keep the last byte
    repeat (4) @(negedge clk_in);
    rd_n_out = 1'b0;
    repeat (8) @(negedge clk_in);
    b = {dev_oe_in, dev_data_in};
    rd_n_out = 1'b1;
    repeat (8) @(negedge clk_in);
  endtask : rd
endmodule : host_bus_model

/* File: verif/display_status_readback_tb_top.sv */
// testbench: read commands through the host model, each byte checked
// assumes the bound checker watches the same pins
`timescale 1ns/1ps
module display_status_readback_tb_top;
  import readback_pkg::*;
  logic           clk, rstn, sel, rd_n, wr_n, oe;
  logic [7:0]     din, dout;
  display_state_t st;
  int             fails, n_checks, cyc;
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  host_bus_model h (.clk_in(clk), .dev_data_in(dout), .dev_oe_in(oe), .sel_out(sel),
    .rd_n_out(rd_n), .wr_n_out(wr_n), .data_out(din));
  display_status_readback uut (.core_clk_in(clk), .resetn_in(rstn),
    .data_command_select_in(sel), .read_strobe_n_in(rd_n), .write_strobe_n_in(wr_n),
    .host_data_in(din), .host_data_out(dout), .host_data_oe_out(oe), .state_in(st));
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude;
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  // state is swapped after the command so stale sampling shows up
  task automatic run(input logic [7:0] c, input int n, input logic [39:0] e,
                     input display_state_t s);
    logic [8:0] b;
    h.cmd(c);
    st = s;
    for (int i = 0; i < n; i++) begin
      h.rd(1'b1, b);
      check(b, {1'b1, e[39 - 8 * i -: 8]});
    end
  endtask : run
  task automatic t_ident;
    run(CMD_READ_IDENTIFY, 5, 40'h005a013c00, st);
  endtask : t_ident
  task automatic t_status_power;
    display_state_t s;
    logic [31:0]    w;
    logic [7:0]     p;
    for (int k = 0; k < 2; k++) begin
      s = display_state_t'(k ? 20'h00000 : 20'hfffff);
      s.pixel_format = k ? PIXEL_FORMAT_18BPP : PIXEL_FORMAT_16BPP;
      s.memory_access_control_setting = k ? 6'h29 : 6'h16;
      w = {s.booster_ok, s.memory_access_control_setting, 2'h0, s.pixel_format,
           s.idle_on, s.partial_on, s.sleep_out, s.normal_on, 5'h00,
           s.display_on, s.tearing_line_on, s.gamma_curve, s.tearing_mode, 5'h00};
      p = {s.booster_ok, s.idle_on, s.partial_on, s.sleep_out, s.normal_on,
           s.display_on, 2'h0};
      st = ~s;
      run(CMD_READ_STATUS_WORD, 5, {8'h00, w}, s);
      run(CMD_READ_POWER_STATE, 3, {8'h00, p, 24'h000000}, s);
    end
  endtask : t_status_power
  task automatic t_refuse;
    logic [8:0] b;
    h.cmd(CMD_READ_POWER_STATE);
    h.rd(1'b0, b);
    check({b[8], 8'h00}, 9'h000);
    h.rd(1'b1, b);
    check(b, {1'b1, DUMMY_BYTE});
    run(CMD_SOFT_RESET, 2, 40'h0, st);
  endtask : t_refuse
  // reset after a read command drops the pending sequence and leaves the bus undriven
  task automatic t_reset;
    logic [8:0] b;
    h.cmd(CMD_READ_IDENTIFY);
    rstn = 1'b0;
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    check({oe, dout}, 9'h000);
    h.rd(1'b1, b);
    check(b, {1'b1, DUMMY_BYTE});
    h.rd(1'b1, b);
    check(b, 9'h100);
  endtask : t_reset
  initial begin
    rstn = 1'b0;
    st = display_state_t'(20'h00000);
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    t_ident();
    t_status_power();
    t_refuse();
    t_reset();
    conclude();
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fails++;
      conclude();
    end
  end
endmodule : display_status_readback_tb_top
